/* rtl/fwd_policy_cfg.svh */
// Register map, field positions, reset values and timing of the policy bank
`ifndef FWD_POLICY_CFG_SVH
`define FWD_POLICY_CFG_SVH

// Register offsets
`define ADDR_UMC_CTRL   8'h84
`define ADDR_UVID_CTRL  8'h85
`define ADDR_SELF_CTRL  8'h86
`define ADDR_RATE_CTRL  8'h87
`define ADDR_DSCP_BASE  8'h90
`define ADDR_DSCP_LAST  8'h9F

// Reset values, reserved bits included
`define RST_UMC_CTRL    8'h40
`define RST_UVID_CTRL   8'h00
`define RST_SELF_CTRL   8'h00
`define RST_RATE_CTRL   8'h10

// Writable bits of each register
`define WMASK_UMC       8'h3F
`define WMASK_UVID      8'h3F
`define WMASK_SELF      8'h7F
`define WMASK_RATE      8'h3C

// Field positions
`define BIT_FWD_EN      5
`define BIT_SELF_FILT   6
`define BIT_QUEUE_RL    3
`define BIT_SRC_PVID    2
`define MAP_MSB         4
`define MAP_RSVD        3
`define PERIOD_MSB      5
`define PERIOD_LSB      4
`define TOS_DSCP_MSB    7
`define TOS_DSCP_LSB    2

// Window multiples of the 16 ms base
`define WIN_MULT_16     5'h01
`define WIN_MULT_64     5'h04
`define WIN_MULT_256    5'h10

// Timing
`define MCLK_PERIOD_NS  50
`define PERIOD_BASE_MS  16
`define NS_PER_MS       1000000

`endif

/* rtl/fwd_policy_pkg.sv */
// Types shared by the forwarding policy bank
package fwd_policy_pkg;

   typedef enum logic [1:0] {
      PKT_KNOWN,
      PKT_UNK_MCAST,
      PKT_UNK_VID,
      PKT_UNK_IPMC
   } pkt_class_type;

   typedef struct packed {
      logic [7:0] umc;
      logic [7:0] uvid;
      logic [7:0] self;
      logic [7:0] rate;
      logic [7:0] rdata;
      logic       fwd_valid;
      logic [3:0] fwd_mask;
      logic       egr_valid;
      logic       egr_discard;
      logic       egr_insert;
   } policy_state_type;

   typedef struct packed {
      logic [19:0] cyc;
      logic [4:0]  sub;
      logic [1:0]  sel;
      logic        tick;
   } timer_state_type;

   typedef struct packed {
      logic [15:0][7:0] tbl;
      logic [1:0]       prio;
      logic             valid;
   } dscp_state_type;

endpackage : fwd_policy_pkg

/* rtl/policy_if.sv */
// Links the register bank to its DSCP table and window timer
`timescale 1ns/100ps
`default_nettype none
interface policy_if;
   logic       tbl_we;
   logic [3:0] tbl_idx;
   logic [7:0] tbl_wdata;
   logic [7:0] tbl_rdata;
   logic       lkp_valid;
   logic [7:0] lkp_tos;
   logic [1:0] prio;
   logic       prio_valid;
   logic [1:0] period_sel;
   logic       period_tick;

   modport ctrl (output tbl_we, tbl_idx, tbl_wdata, lkp_valid, lkp_tos, period_sel,
                 input  tbl_rdata, prio, prio_valid, period_tick);
   modport tbl_side (input tbl_we, tbl_idx, tbl_wdata, lkp_valid, lkp_tos,
                     output tbl_rdata, prio, prio_valid);
   modport timer (input period_sel, output period_tick);
endinterface : policy_if
`default_nettype wire

/* rtl/dscp_priority_map.sv */
// DSCP priority table: 64 two-bit entries, written by software, read per frame
`timescale 1ns/100ps
`default_nettype none
`include "fwd_policy_cfg.svh"
module dscp_priority_map
   import fwd_policy_pkg::*;
(
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rst_n,
   // Table access and lookup
   policy_if.tbl_side tp
);

   dscp_state_type st_r;
   dscp_state_type st_nxt;

   function automatic logic [1:0] dscp_field(input logic [15:0][7:0] t,
                                             input logic [5:0]       c);
      return t[c[5:2]][{c[1:0], 1'b0} +: 2];
   endfunction : dscp_field

   always_comb begin
      st_nxt = st_r;
      if (tp.tbl_we) begin
         st_nxt.tbl[tp.tbl_idx] = tp.tbl_wdata;
      end
      st_nxt.valid = tp.lkp_valid;
      // Lookup sees the table as it stood before a same-cycle write
      if (tp.lkp_valid) begin
         st_nxt.prio = dscp_field(st_r.tbl, tp.lkp_tos[`TOS_DSCP_MSB:`TOS_DSCP_LSB]);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tp.tbl_rdata  = st_r.tbl[tp.tbl_idx];
   assign tp.prio       = st_r.prio;
   assign tp.prio_valid = st_r.valid;

   a_dscp_lookup: assert property (@(posedge mclk) disable iff (!rst_n)
      tp.lkp_valid |=> tp.prio_valid &&
         tp.prio == dscp_field($past(st_r.tbl), $past(tp.lkp_tos[7:2])))
      else $error("DSCP priority does not match table entry");

   c_dscp_hit: cover property (@(posedge mclk) disable iff (!rst_n)
      tp.prio_valid && tp.prio != 2'h0);

endmodule : dscp_priority_map
`default_nettype wire

/* rtl/rate_window_timer.sv */
// Ingress rate limit measurement window: one tick per 16, 64 or 256 ms
`timescale 1ns/100ps
`default_nettype none
`include "fwd_policy_cfg.svh"
module rate_window_timer
   import fwd_policy_pkg::*;
#(
   parameter logic [19:0] BASE_CYC = 20'(`PERIOD_BASE_MS * `NS_PER_MS / `MCLK_PERIOD_NS)
) (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rst_n,
   // Window select and tick
   policy_if.timer   tm
);

   timer_state_type st_r;
   timer_state_type st_nxt;
   logic [23:0]     gap_r;
   logic            seen_r;

   function automatic logic [4:0] win_mult(input logic [1:0] sel);
      return sel[1] ? `WIN_MULT_256 : (sel[0] ? `WIN_MULT_64 : `WIN_MULT_16);
   endfunction : win_mult

   always_comb begin
      st_nxt      = st_r;
      st_nxt.tick = 1'b0;
      st_nxt.sel  = tm.period_sel;
      // A new window size restarts the count so no short window leaks out
      if (tm.period_sel != st_r.sel) begin
         st_nxt.cyc = '0;
         st_nxt.sub = '0;
      end else if (st_r.cyc == BASE_CYC - 20'h0_0001) begin
         st_nxt.cyc = '0;
         if (st_r.sub == win_mult(st_r.sel) - 5'h01) begin
            st_nxt.sub  = '0;
            st_nxt.tick = 1'b1;
         end else begin
            st_nxt.sub = st_r.sub + 5'h01;
         end
      end else begin
         st_nxt.cyc = st_r.cyc + 20'h0_0001;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '{cyc: '0, sub: '0, sel: 2'(`RST_RATE_CTRL >> `PERIOD_LSB), tick: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tm.period_tick = st_r.tick;

   // Helper: cycles since the last tick under an unchanged selection
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gap_r  <= '0;
         seen_r <= 1'b0;
      end else if (tm.period_sel != st_r.sel) begin
         gap_r  <= '0;
         seen_r <= 1'b0;
      end else if (st_r.tick) begin
         gap_r  <= 24'h00_0001;
         seen_r <= 1'b1;
      end else begin
         gap_r  <= gap_r + 24'h00_0001;
      end
   end

   a_window_len: assert property (@(posedge mclk) disable iff (!rst_n)
      st_r.tick && seen_r |-> gap_r == 24'(BASE_CYC) * 24'(win_mult(st_r.sel)))
      else $error("Rate window length wrong for selected period");

   c_window_tick: cover property (@(posedge mclk) disable iff (!rst_n)
      st_r.tick && seen_r);

endmodule : rate_window_timer
`default_nettype wire

/* rtl/switch_unknown_forward_policy.sv */
// Forwarding policy registers for unknown traffic, self filter, rate and PVID
//
// Contract
// - The unknown multicast map drops at 00000, reaches ports 1, 1-2 or 1-3, floods at 11111, resets to zero.
// - Bit 3 of every unknown-packet port map is kept but never steers forwarding.
// - Bit 5 of the unknown VID register enables its special forwarding and resets to zero.
// - The unknown VID map drops at 00000, reaches ports 1, 1-2 or 1-3, floods at 11111.
// - Bit 6 of the self filter register discards frames addressed to the switch itself, reset zero.
// - The self filter acts at the egress port against the configured own MAC address.
// - Bit 5 of the self filter register enables unknown IP multicast forwarding, reset zero.
// - The unknown IP multicast map drops at 00000, reaches ports 1, 1-2 or 1-3, floods at 11111.
// - The ingress rate window is 16 ms for 00, 64 ms for 01, 256 ms for 1x, 64 ms after reset.
// - Bit 3 of the rate register selects port based (0, reset) or queue based (1) egress limiting.
// - With bit 2 set, PVID insertion follows the per-source selection of the egress port.
// - With bit 2 clear, PVID insertion follows the egress port's own insertion bit only.
// - The upper six bits of the TOS or traffic class byte pick one of 64 table entries.
// - The unknown multicast enable does not cover IP multicast, which has its own control.
// - Each table entry is a two-bit priority used for the frame, all reset to zero.
`timescale 1ns/100ps
`default_nettype none
`include "fwd_policy_cfg.svh"
module switch_unknown_forward_policy
   import fwd_policy_pkg::*;
#(
   parameter logic [19:0] PERIOD_BASE_CYC = 20'(`PERIOD_BASE_MS * `NS_PER_MS / `MCLK_PERIOD_NS)
) (
   // Clock and reset
   input  wire logic          mclk,
   input  wire logic          rst_n,
   // Register port
   input  wire logic [7:0]    reg_addr,
   input  wire logic [7:0]    reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic [7:0]         reg_rdata,
   // Forwarding lookup
   input  wire logic          lkp_valid,
   input  wire pkt_class_type lkp_class,
   input  wire logic [3:0]    lkp_def_mask,
   output logic               fwd_valid,
   output logic [3:0]         fwd_mask,
   // Egress decision
   input  wire logic          egr_valid,
   input  wire logic [47:0]   egr_da,
   input  wire logic [47:0]   self_mac,
   input  wire logic [1:0]    egr_src_port,
   input  wire logic          port_tag_ins,
   input  wire logic [3:0]    src_ins_sel,
   output logic               egr_done,
   output logic               egr_discard,
   output logic               egr_insert_pvid,
   // Rate limiting
   output logic               queue_rate_mode,
   output logic               rate_tick,
   // DSCP priority lookup
   input  wire logic          ip_valid,
   input  wire logic [7:0]    ip_tos,
   output logic               prio_valid,
   output logic [1:0]         prio
);

   localparam policy_state_type POLICY_RST = '{
      umc:         `RST_UMC_CTRL,
      uvid:        `RST_UVID_CTRL,
      self:        `RST_SELF_CTRL,
      rate:        `RST_RATE_CTRL,
      rdata:       '0,
      fwd_valid:   1'b0,
      fwd_mask:    '0,
      egr_valid:   1'b0,
      egr_discard: 1'b0,
      egr_insert:  1'b0
   };

   policy_state_type st_r;
   policy_state_type st_nxt;
   policy_if         bus ();

   // Port mask bit n stands for port n+1; map bit 3 has no port behind it
   function automatic logic [3:0] map_to_ports(input logic [7:0] ctrl);
      return {ctrl[`MAP_MSB], ctrl[`MAP_RSVD-1:0]};
   endfunction : map_to_ports

   function automatic logic [7:0] merge_wr(input logic [7:0] old,
                                           input logic [7:0] wdat,
                                           input logic [7:0] wmask);
      return (old & ~wmask) | (wdat & wmask);
   endfunction : merge_wr

   function automatic logic in_dscp(input logic [7:0] a);
      return a >= `ADDR_DSCP_BASE && a <= `ADDR_DSCP_LAST;
   endfunction : in_dscp

   // Map only while enabled, else the switch's normal choice
   function automatic logic [3:0] pick(input logic [7:0] ctrl, input logic [3:0] def);
      return ctrl[`BIT_FWD_EN] ? map_to_ports(ctrl) : def;
   endfunction : pick

   // Port 4 bit of the map in use for a class, zero while that map is off
   function automatic logic fwd_mask_src_bit4(input pkt_class_type c, input logic [7:0] umc,
                                              input logic [7:0] uvid, input logic [7:0] ipmc);
      case (c)
         PKT_UNK_MCAST: return umc[`BIT_FWD_EN] && umc[`MAP_MSB];
         PKT_UNK_VID:   return uvid[`BIT_FWD_EN] && uvid[`MAP_MSB];
         PKT_UNK_IPMC:  return ipmc[`BIT_FWD_EN] && ipmc[`MAP_MSB];
         default:       return 1'b0;
      endcase
   endfunction : fwd_mask_src_bit4

   always_comb begin
      st_nxt = st_r;

      // Register writes; reserved bits keep their reset value
      if (reg_wr) begin
         case (reg_addr)
            `ADDR_UMC_CTRL: begin
               st_nxt.umc = merge_wr(st_r.umc, reg_wdata, `WMASK_UMC);
            end
            `ADDR_UVID_CTRL: begin
               st_nxt.uvid = merge_wr(st_r.uvid, reg_wdata, `WMASK_UVID);
            end
            `ADDR_SELF_CTRL: begin
               st_nxt.self = merge_wr(st_r.self, reg_wdata, `WMASK_SELF);
            end
            `ADDR_RATE_CTRL: begin
               st_nxt.rate = merge_wr(st_r.rate, reg_wdata, `WMASK_RATE);
            end
            default: begin
            end
         endcase
      end

      // Read data stands for exactly one cycle; unmapped reads give zero
      st_nxt.rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            `ADDR_UMC_CTRL: begin
               st_nxt.rdata = st_r.umc;
            end
            `ADDR_UVID_CTRL: begin
               st_nxt.rdata = st_r.uvid;
            end
            `ADDR_SELF_CTRL: begin
               st_nxt.rdata = st_r.self;
            end
            `ADDR_RATE_CTRL: begin
               st_nxt.rdata = st_r.rate;
            end
            default: begin
               if (in_dscp(reg_addr)) begin
                  st_nxt.rdata = bus.tbl_rdata;
               end
            end
         endcase
      end

      // Forwarding choice for packets the address table could not place
      st_nxt.fwd_valid = lkp_valid;
      if (lkp_valid) begin
         case (lkp_class)
            PKT_UNK_MCAST: begin
               st_nxt.fwd_mask = pick(st_r.umc, lkp_def_mask);
            end
            PKT_UNK_VID: begin
               st_nxt.fwd_mask = pick(st_r.uvid, lkp_def_mask);
            end
            PKT_UNK_IPMC: begin
               st_nxt.fwd_mask = pick(st_r.self, lkp_def_mask);
            end
            default: begin
               st_nxt.fwd_mask = lkp_def_mask;
            end
         endcase
      end

      // Egress: self filter and PVID insertion
      st_nxt.egr_valid = egr_valid;
      if (egr_valid) begin
         st_nxt.egr_discard = st_r.self[`BIT_SELF_FILT] && egr_da == self_mac;
         if (st_r.rate[`BIT_SRC_PVID]) begin
            st_nxt.egr_insert = src_ins_sel[egr_src_port];
         end else begin
            st_nxt.egr_insert = port_tag_ins;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= POLICY_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Table and timer hookup
   assign bus.tbl_we     = reg_wr && in_dscp(reg_addr);
   assign bus.tbl_idx    = reg_addr[3:0];
   assign bus.tbl_wdata  = reg_wdata;
   assign bus.lkp_valid  = ip_valid;
   assign bus.lkp_tos    = ip_tos;
   assign bus.period_sel = st_r.rate[`PERIOD_MSB:`PERIOD_LSB];

   dscp_priority_map u_dscp (
      .mclk  (mclk),
      .rst_n (rst_n),
      .tp    (bus.tbl_side)
   );

   rate_window_timer #(
      .BASE_CYC (PERIOD_BASE_CYC)
   ) u_timer (
      .mclk  (mclk),
      .rst_n (rst_n),
      .tm    (bus.timer)
   );

   // Outputs
   assign reg_rdata       = st_r.rdata;
   assign fwd_valid       = st_r.fwd_valid;
   assign fwd_mask        = st_r.fwd_mask;
   assign egr_done        = st_r.egr_valid;
   assign egr_discard     = st_r.egr_discard;
   assign egr_insert_pvid = st_r.egr_insert;
   assign queue_rate_mode = st_r.rate[`BIT_QUEUE_RL];
   assign rate_tick       = bus.period_tick;
   assign prio_valid      = bus.prio_valid;
   assign prio            = bus.prio;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_umc_drop_flood: assert property (
      lkp_valid && lkp_class == PKT_UNK_MCAST && st_r.umc[5] |=>
         fwd_valid && fwd_mask == {$past(st_r.umc[4]), $past(st_r.umc[2:0])})
      else $error("Unknown multicast map not applied");

   a_map_bit3_ignored: assert property (
      lkp_valid && lkp_class != PKT_KNOWN && lkp_def_mask == 4'h0 |=>
         fwd_mask[3] == $past(fwd_mask_src_bit4(lkp_class, st_r.umc, st_r.uvid, st_r.self)))
      else $error("Reserved map bit leaked into port mask");

   a_uvid_disabled: assert property (
      lkp_valid && lkp_class == PKT_UNK_VID && !st_r.uvid[5] |=>
         fwd_mask == $past(lkp_def_mask))
      else $error("Disabled unknown VID map still applied");

   a_uvid_map: assert property (
      lkp_valid && lkp_class == PKT_UNK_VID && st_r.uvid[5] |=>
         fwd_mask == {$past(st_r.uvid[4]), $past(st_r.uvid[2:0])})
      else $error("Unknown VID map not applied");

   a_self_discard: assert property (
      egr_valid |=> egr_done &&
         egr_discard == ($past(st_r.self[6]) && $past(egr_da) == $past(self_mac)))
      else $error("Self address filter decision wrong");

   a_ipmc_map: assert property (
      lkp_valid && lkp_class == PKT_UNK_IPMC |=>
         fwd_mask == ($past(st_r.self[5]) ?
            {$past(st_r.self[4]), $past(st_r.self[2:0])} : $past(lkp_def_mask)))
      else $error("Unknown IP multicast forwarding wrong");

   a_ipmc_not_umc: assert property (
      lkp_valid && lkp_class == PKT_UNK_IPMC && !st_r.self[5] && st_r.umc[5] |=>
         fwd_mask == $past(lkp_def_mask))
      else $error("Multicast map applied to IP multicast");

   a_queue_mode: assert property (
      reg_wr && reg_addr == `ADDR_RATE_CTRL |=> queue_rate_mode == $past(reg_wdata[3]))
      else $error("Egress limit mode not taken from write");

   a_pvid_choice: assert property (
      egr_valid |=> egr_insert_pvid == ($past(st_r.rate[2]) ?
         $past(src_ins_sel[egr_src_port]) : $past(port_tag_ins)))
      else $error("PVID insertion choice wrong");

   a_reserved_hold: assert property (
      reg_wr && reg_addr == `ADDR_UMC_CTRL |=>
         (st_r.umc & ~`WMASK_UMC) == (`RST_UMC_CTRL & ~`WMASK_UMC))
      else $error("Reserved bits changed by write");

   a_read_one_cycle: assert property (
      reg_rd ##1 !reg_rd |=> reg_rdata == 8'h00)
      else $error("Read data held too long");

   a_uvid_reserved: assert property (
      reg_wr && reg_addr == `ADDR_UVID_CTRL |=>
         (st_r.uvid & ~`WMASK_UVID) == (`RST_UVID_CTRL & ~`WMASK_UVID))
      else $error("Reserved unknown VID bits changed by write");

   a_self_reserved: assert property (
      reg_wr && reg_addr == `ADDR_SELF_CTRL |=>
         (st_r.self & ~`WMASK_SELF) == (`RST_SELF_CTRL & ~`WMASK_SELF))
      else $error("Reserved self filter bit changed by write");

   a_rate_reserved: assert property (
      reg_wr && reg_addr == `ADDR_RATE_CTRL |=>
         (st_r.rate & ~`WMASK_RATE) == (`RST_RATE_CTRL & ~`WMASK_RATE))
      else $error("Reserved rate bits changed by write");

   a_period_follow: assert property (
      reg_wr && reg_addr == `ADDR_RATE_CTRL |=>
         bus.period_sel == $past(reg_wdata[`PERIOD_MSB:`PERIOD_LSB]))
      else $error("Window select not taken from write");

   a_known_default: assert property (
      lkp_valid && lkp_class == PKT_KNOWN |=> fwd_mask == $past(lkp_def_mask))
      else $error("Known traffic mask not passed through");

   a_umc_disabled: assert property (
      lkp_valid && lkp_class == PKT_UNK_MCAST && !st_r.umc[`BIT_FWD_EN] |=>
         fwd_mask == $past(lkp_def_mask))
      else $error("Disabled multicast map still applied");

   a_fwd_pulse: assert property (
      fwd_valid == $past(lkp_valid))
      else $error("Lookup answer not one cycle after request");

   a_egr_pulse: assert property (
      egr_done == $past(egr_valid))
      else $error("Egress answer not one cycle after request");

   a_mask_holds: assert property (
      !lkp_valid |=> $stable(fwd_mask))
      else $error("Forwarding mask changed without lookup");

   a_egr_holds: assert property (
      !egr_valid |=> $stable({egr_discard, egr_insert_pvid}))
      else $error("Egress decision changed without request");

   a_self_off: assert property (
      egr_valid && !st_r.self[`BIT_SELF_FILT] |=> !egr_discard)
      else $error("Frame dropped with self filter off");

   c_umc_flood: cover property (
      fwd_valid && fwd_mask == 4'hF && $past(lkp_class) == PKT_UNK_MCAST);
   c_self_drop: cover property (egr_done && egr_discard);
   c_src_pvid: cover property (egr_done && $past(st_r.rate[2]) && egr_insert_pvid);

endmodule : switch_unknown_forward_policy
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the unknown traffic forwarding policy bank
`timescale 1ns/100ps
`default_nettype none
`include "fwd_policy_cfg.svh"
module tb;
   import fwd_policy_pkg::*;
   // Shortened 16 ms base so all three windows fit in a short run
   localparam logic [19:0] BASE = 20'h0_0014;
   localparam logic [4:0] MAPS[5] = '{5'h00, 5'h01, 5'h03, 5'h07, 5'h1f};
   logic          mclk;
   logic          rst_n;
   logic [7:0]    reg_addr;
   logic [7:0]    reg_wdata;
   logic          reg_wr;
   logic          reg_rd;
   logic [7:0]    reg_rdata;
   logic          lkp_valid;
   pkt_class_type lkp_class;
   logic [3:0]    lkp_def_mask;
   logic          fwd_valid;
   logic [3:0]    fwd_mask;
   logic          egr_valid;
   logic [47:0]   egr_da;
   logic [47:0]   self_mac;
   logic [1:0]    egr_src_port;
   logic          port_tag_ins;
   logic [3:0]    src_ins_sel;
   logic          egr_done;
   logic          egr_discard;
   logic          egr_insert_pvid;
   logic          queue_rate_mode;
   logic          rate_tick;
   logic          ip_valid;
   logic [7:0]    ip_tos;
   logic          prio_valid;
   logic [1:0]    prio;
   int            errors;
   int            compares;
   logic [31:0]   seed;
   logic          rd_d;
   logic [7:0]    rd_q[$];
   logic [7:0]    fwd_q[$];
   logic [7:0]    egr_q[$];
   logic [7:0]    pr_q[$];
   logic [7:0]    dscp_r[16];

   switch_unknown_forward_policy #(.PERIOD_BASE_CYC(BASE)) u_dut (
      .mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .lkp_valid, .lkp_class, .lkp_def_mask, .fwd_valid, .fwd_mask,
      .egr_valid, .egr_da, .self_mac, .egr_src_port, .port_tag_ins, .src_ins_sel,
      .egr_done, .egr_discard, .egr_insert_pvid, .queue_rate_mode, .rate_tick,
      .ip_valid, .ip_tos, .prio_valid, .prio
   );

   initial mclk = 1'b0;
   always #25 mclk = ~mclk;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   task automatic pop_chk(input string what, ref logic [7:0] q[$], input logic [7:0] got);
      if (q.size() == 0) begin
         errors++;
         $display("[ERR] %s expected none seen %0h", what, got);
      end else begin
         chk(what, q.pop_front(), got);
      end
   endtask : pop_chk

   // Results are matched against the oldest note of their kind
   always @(posedge mclk) begin
      if (rd_d === 1'b1) pop_chk("reg_rdata", rd_q, reg_rdata);
      if (fwd_valid === 1'b1) pop_chk("fwd_mask", fwd_q, {4'h0, fwd_mask});
      if (egr_done === 1'b1) pop_chk("egress", egr_q, {6'h00, egr_discard, egr_insert_pvid});
      if (prio_valid === 1'b1) pop_chk("prio", pr_q, {6'h00, prio});
      rd_d <= reg_rd;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      rd_q.push_back(exp);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
   endtask : rd

   task automatic lk(input logic [7:0] exp);
      fwd_q.push_back(exp);
      @(posedge mclk);
      lkp_valid <= 1'b1;
      @(posedge mclk);
      lkp_valid <= 1'b0;
   endtask : lk

   task automatic eg(input logic [7:0] exp);
      egr_q.push_back(exp);
      @(posedge mclk);
      egr_valid <= 1'b1;
      @(posedge mclk);
      egr_valid <= 1'b0;
   endtask : eg

   task automatic ipl(input logic [7:0] exp);
      pr_q.push_back(exp);
      @(posedge mclk);
      ip_valid <= 1'b1;
      @(posedge mclk);
      ip_valid <= 1'b0;
   endtask : ipl

   // Ticks are sampled just after the edge, once the design has updated
   task automatic meas(input int exp);
      int n;
      n = 0;
      while (rate_tick !== 1'b1 && n < 2000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      n = 0;
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while (rate_tick !== 1'b1 && n < 2000);
      chk("rate window", exp, n);
   endtask : meas

   task automatic finish_test;
      $display("Comparisons %0d mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test

   initial begin : watchdog
      #1_000_000;
      errors++;
      finish_test();
   end

   initial begin : main
      logic [31:0] r;
      logic [7:0]  v;
      logic [4:0]  m;
      logic [5:0]  code;
      rst_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      lkp_valid = 1'b0;
      lkp_class = PKT_KNOWN;
      lkp_def_mask = 4'h0;
      egr_valid = 1'b0;
      egr_da = 48'h0;
      self_mac = 48'h0;
      egr_src_port = 2'b00;
      port_tag_ins = 1'b0;
      src_ins_sel = 4'h0;
      ip_valid = 1'b0;
      ip_tos = 8'h00;
      errors = 0;
      compares = 0;
      rd_d = 1'b0;
      seed = 32'h0000_1b1c;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      rd(8'h84, 8'h40);
      rd(8'h85, 8'h00);
      rd(8'h86, 8'h00);
      rd(8'h87, 8'h10);
      rd(8'h80, 8'h00);
      ip_tos <= 8'hff;
      ipl(8'h00);
      meas(4 * BASE);
      // Software keeps reserved bits at their reset level
      for (int k = 0; k < 3; k++) begin
         v = 8'(rnd()) & (k == 2 ? 8'h7f : 8'h3f) | (k == 0 ? 8'h40 : 8'h00);
         wr(8'h84 + k, v);
         rd(8'h84 + k, v);
      end
      for (int c = 0; c < 4; c++) begin
         for (int j = 0; j < 12; j++) begin
            r = rnd();
            m = (j < 10) ? MAPS[j / 2] : r[12:8];
            wr(8'h84 + ((c == 0) ? 0 : c - 1), {(c < 2) ? 2'b01 : 2'b00, r[0] | j[0], m});
            lkp_class <= pkt_class_type'(c);
            lkp_def_mask <= r[7:4];
            v = (c != 0 && (r[0] | j[0])) ? {4'h0, m[4], m[2:0]} : {4'h0, r[7:4]};
            lk(v);
         end
      end
      for (int j = 0; j < 24; j++) begin
         r = rnd();
         wr(8'h86, {1'b0, r[0], 6'h00});
         wr(8'h87, {4'h1, 1'b0, r[1], 2'b00});
         self_mac <= {rnd(), r[31:16]};
         egr_da <= r[2] ? {seed, r[31:16]} : {seed, r[31:16]} ^ (48'h1 << r[9:5]);
         egr_src_port <= r[12:11];
         port_tag_ins <= r[13];
         src_ins_sel <= r[17:14];
         v = {6'h00, r[0] & r[2], r[1] ? r[14 + r[12:11]] : r[13]};
         eg(v);
      end
      for (int k = 0; k < 16; k++) begin
         dscp_r[k] = 8'(rnd());
         wr(8'h90 + k, dscp_r[k]);
         rd(8'h90 + k, dscp_r[k]);
      end
      for (int k = 0; k < 64; k++) begin
         code = 6'(k);
         r = rnd();
         ip_tos <= {code, r[1:0]};
         ipl({6'h00, dscp_r[code[5:2]][2 * code[1:0] +: 2]});
      end
      for (int k = 0; k < 4; k++) begin
         v = 8'((rnd() & 8'h0c) | (k << 4));
         wr(8'h87, v);
         rd(8'h87, v & 8'h3c);
         repeat (2) @(posedge mclk);
         #1;
         chk("queue_rate_mode", v[3], queue_rate_mode);
         meas(BASE * (k == 0 ? 1 : (k == 1 ? 4 : 16)));
      end
      repeat (4) @(posedge mclk);
      chk("pending", 0, rd_q.size() + fwd_q.size() + egr_q.size() + pr_q.size());
      finish_test();
   end
endmodule : tb
`default_nettype wire
